// [rei_event_core.sv]
`default_nettype none
// Summary of operation
// - Update event each second or minute rollover
// - Update event sets flag; interrupt if enabled
// - Update low pulse self-releases after set time
// - Clearing flag or enable releases pulse
// - Update flag sticks until software clears
// - Update pulse may switch clock output on
// - Update events always run; enable gates pin
// - Reset bit or seconds write restarts period
// - First update only at next rollover
// - Alarm match sets flag; interrupt if enabled
// - Alarm signal may switch clock output on
// - Select bit picks weekday or date compare
// - Per-register participate bits steer alarm match
// - Reset bit or seconds write shifts alarm
// - External event captures time, flags, interrupts
// - Trigger type picks edge or filtered level
// - Polarity one means rising edge, high level
// - Event signal may switch clock output on
// - Backup switchover sets event flag when selected and time stamp enabled
// - Trigger type zero edge, else level
module rei_event_core
	import rei_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = 7'h52,
	parameter int SEC_CYC = ONE_SEC_CYC,
	parameter int RSEC_CYC = REL_SEC_CYC,
	parameter int RMIN_CYC = REL_MIN_CYC
) (
	input wire logic ref_clk, // 100 MHz clock
	input wire logic reset_n, // Synchronous reset, active low
	input wire logic scl_in, // Serial clock pin
	input wire logic sda_in, // Serial data pin, input side
	output logic sda_out, // Serial data pin, output side
	output logic sda_oe, // Serial data drive enable
	input wire logic event_input_pin, // External event pin
	input wire logic backup_switch_in, // Backup switchover event
	output logic int_n, // Shared interrupt, active low
	output logic clkout // Programmable clock output
);
	import rei_pkg::*;

	logic [3:0] pins;
	logic scl_q_ff, sda_q_ff, evi_q_ff, bsw_q_ff;
	rei_i2c_st_t st_ff;
	logic [3:0] bit_ff;
	logic [7:0] sh_ff, ptr_ff, wr_addr_ff, wr_data_ff, rd_byte;
	logic wr_en_ff, rd_ff;
	logic [26:0] presc_ff;
	logic [7:0] sec_ff, min_ff, hour_ff, wday_ff, date_ff;
	logic [7:0] alm_min_ff, alm_hour_ff, alm_day_ff;
	logic [7:0] ctrl1_ff, ctrl2_ff, mask_ff, evctl_ff, clkcfg_ff;
	logic [7:0] ts_sec_ff, ts_min_ff, ts_hour_ff, ts_date_ff;
	logic update_flag_ff, alarm_flag_ff, event_flag_ff;
	logic upd_act_ff, alm_chk_ff, clk_auto_ff;
	logic [25:0] upd_cnt_ff, div_ff;
	logic [2:0] lvl_cnt_ff;

	rei_pin_sync #(.W(4), .RST_VAL(4'h3)) rei_pin_sync_i (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.pin_in({backup_switch_in, event_input_pin, sda_in, scl_in}),
		.pin_out(pins)
	);

	wire scl_s = pins[0];
	wire sda_s = pins[1];
	wire evi_s = pins[2];
	wire bsw_s = pins[3];
	wire scl_rise = scl_s & ~scl_q_ff;
	wire scl_fall = ~scl_s & scl_q_ff;
	wire i2c_start = scl_s & scl_q_ff & sda_q_ff & ~sda_s;
	wire i2c_stop = scl_s & scl_q_ff & ~sda_q_ff & sda_s;

	// ------------------------------------------------------------
	// Control fields
	// ------------------------------------------------------------
	wire update_source_select = ctrl1_ff[B_UPDATE_SOURCE_SELECT];
	wire weekday_or_date_select = ctrl1_ff[B_WEEKDAY_OR_DATE_SELECT];
	wire update_irq_enable = ctrl2_ff[B_UIE];
	wire alarm_irq_enable = ctrl2_ff[B_AIE];
	wire event_irq_enable = ctrl2_ff[B_EIE];
	wire timestamp_enable = ctrl2_ff[B_TSE];
	wire timestamp_source_select = evctl_ff[B_TSS];
	wire event_polarity = evctl_ff[B_EHL];
	wire [1:0] ettype = evctl_ff[B_ET_HI:B_ET_LO];
	wire clock_output_enable = clkcfg_ff[B_CLOCK_OUTPUT_ENABLE];
	wire clock_irq_gate_enable = clkcfg_ff[B_CLOCK_IRQ_GATE_ENABLE];
	wire [2:0] fdsel = clkcfg_ff[2:0];
	wire wr_sec = wr_en_ff && wr_addr_ff == OFS_SECONDS;
	wire wr_rst = wr_en_ff && wr_addr_ff == OFS_CTRL2 &&
		wr_data_ff[B_RESET];
	wire wr_stat = wr_en_ff && wr_addr_ff == OFS_STATUS;

	function automatic logic [7:0] bcd_next(input logic [7:0] v,
		input logic [7:0] last, input logic [7:0] first);
		if (v == last)
			return first;
		else if (v[3:0] == 4'h9)
			return {v[7:4] + 4'h1, 4'h0};
		else
			return v + 8'h01;
	endfunction : bcd_next

	function automatic logic [25:0] half_period(input logic [2:0] fd);
		unique case (fd)
			3'h0: return 26'(HALF_32K);
			3'h1: return 26'(HALF_8K);
			3'h2: return 26'(HALF_1K);
			3'h3: return 26'(HALF_64);
			3'h4: return 26'(HALF_32);
			default: return 26'(HALF_1);
		endcase
	endfunction : half_period

	// ------------------------------------------------------------
	// Serial register port
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			scl_q_ff <= 1'b1;
			sda_q_ff <= 1'b1;
		end else begin
			scl_q_ff <= scl_s;
			sda_q_ff <= sda_s;
		end
	end

	// Address pointer advances once per data byte written or read, not on the device or pointer byte
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			st_ff <= ST_IDLE;
			bit_ff <= 4'h0;
			sh_ff <= 8'h00;
			ptr_ff <= 8'h00;
			rd_ff <= 1'b0;
			sda_oe <= 1'b0;
			sda_out <= 1'b0;
			wr_en_ff <= 1'b0;
			wr_addr_ff <= 8'h00;
			wr_data_ff <= 8'h00;
		end else begin
			wr_en_ff <= 1'b0;
			sda_out <= 1'b0;
			if (i2c_start) begin
				st_ff <= ST_DEV;
				bit_ff <= 4'h0;
				sda_oe <= 1'b0;
			end else if (i2c_stop) begin
				st_ff <= ST_IDLE;
				sda_oe <= 1'b0;
			end else if (scl_rise) begin
				if (st_ff == ST_DEV || st_ff == ST_PTR || st_ff == ST_WDAT) begin
					sh_ff <= {sh_ff[6:0], sda_s};
					bit_ff <= bit_ff + 4'h1;
				end else if (st_ff == ST_RACK && sda_s) begin
					st_ff <= ST_IDLE;
				end
			end else if (scl_fall) begin
				unique case (st_ff)
					ST_IDLE: ;
					ST_DEV: if (bit_ff == 4'h8) begin
						bit_ff <= 4'h0;
						rd_ff <= sh_ff[0];
						sda_oe <= sh_ff[7:1] == DEV_ADDR;
						st_ff <= sh_ff[7:1] == DEV_ADDR ? ST_DACK : ST_IDLE;
					end
					ST_PTR: if (bit_ff == 4'h8) begin
						bit_ff <= 4'h0;
						ptr_ff <= sh_ff;
						sda_oe <= 1'b1;
						st_ff <= ST_PACK;
					end
					ST_WDAT: if (bit_ff == 4'h8) begin
						bit_ff <= 4'h0;
						wr_en_ff <= 1'b1;
						wr_addr_ff <= ptr_ff;
						wr_data_ff <= sh_ff;
						ptr_ff <= ptr_ff + 8'h01;
						sda_oe <= 1'b1;
						st_ff <= ST_WACK;
					end
					ST_DACK, ST_RACK: if (rd_ff) begin
						sh_ff <= rd_byte;
						ptr_ff <= ptr_ff + 8'h01;
						sda_oe <= ~rd_byte[7];
						bit_ff <= 4'h1;
						st_ff <= ST_RDAT;
					end else begin
						sda_oe <= 1'b0;
						st_ff <= ST_PTR;
					end
					ST_PACK, ST_WACK: begin
						sda_oe <= 1'b0;
						st_ff <= ST_WDAT;
					end
					ST_RDAT: if (bit_ff == 4'h8) begin
						bit_ff <= 4'h0;
						sda_oe <= 1'b0;
						st_ff <= ST_RACK;
					end else begin
						sda_oe <= ~sh_ff[6];
						sh_ff <= {sh_ff[6:0], 1'b0};
						bit_ff <= bit_ff + 4'h1;
					end
					default: st_ff <= ST_IDLE;
				endcase
			end
		end
	end

	always_comb begin
		unique case (ptr_ff)
			OFS_SECONDS: rd_byte = sec_ff;
			OFS_MINUTES: rd_byte = min_ff;
			OFS_HOURS: rd_byte = hour_ff;
			OFS_WEEKDAY: rd_byte = wday_ff;
			OFS_DATE: rd_byte = date_ff;
			OFS_ALM_MIN: rd_byte = alm_min_ff;
			OFS_ALM_HOUR: rd_byte = alm_hour_ff;
			OFS_ALM_DAY: rd_byte = alm_day_ff;
			OFS_STATUS: rd_byte = {3'h0, update_flag_ff, 1'b0,
				alarm_flag_ff, event_flag_ff, 1'b0};
			OFS_CTRL1: rd_byte = ctrl1_ff;
			OFS_CTRL2: rd_byte = ctrl2_ff;
			OFS_CLK_MASK: rd_byte = mask_ff;
			OFS_EVT_CTRL: rd_byte = evctl_ff;
			OFS_TS_SEC: rd_byte = ts_sec_ff;
			OFS_TS_MIN: rd_byte = ts_min_ff;
			OFS_TS_HOUR: rd_byte = ts_hour_ff;
			OFS_TS_DATE: rd_byte = ts_date_ff;
			OFS_CLK_CFG: rd_byte = clkcfg_ff;
			default: rd_byte = 8'h00;
		endcase
	end

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	// The reset bit acts as a strobe and always reads back as zero
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			ctrl1_ff <= RST_CTRL;
			ctrl2_ff <= RST_CTRL;
			mask_ff <= RST_CTRL;
			evctl_ff <= RST_CTRL;
			clkcfg_ff <= RST_CLK_CFG;
			alm_min_ff <= RST_CTRL;
			alm_hour_ff <= RST_CTRL;
			alm_day_ff <= RST_CTRL;
		end else if (wr_en_ff) begin
			unique case (wr_addr_ff)
				OFS_CTRL1: ctrl1_ff <= wr_data_ff;
				OFS_CTRL2: ctrl2_ff <= wr_data_ff & 8'hfe;
				OFS_CLK_MASK: mask_ff <= wr_data_ff;
				OFS_EVT_CTRL: evctl_ff <= wr_data_ff;
				OFS_CLK_CFG: clkcfg_ff <= wr_data_ff;
				OFS_ALM_MIN: alm_min_ff <= wr_data_ff;
				OFS_ALM_HOUR: alm_hour_ff <= wr_data_ff;
				OFS_ALM_DAY: alm_day_ff <= wr_data_ff;
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Timekeeping
	// ------------------------------------------------------------
	wire sec_tick = presc_ff == 27'(SEC_CYC - 1);
	wire min_roll = sec_tick && sec_ff == 8'h59;
	wire hour_roll = min_roll && min_ff == 8'h59;
	wire day_roll = hour_roll && hour_ff == 8'h23;

	always_ff @(posedge ref_clk) begin
		if (!reset_n || wr_sec || wr_rst || sec_tick)
			presc_ff <= 27'h000_0000;
		else
			presc_ff <= presc_ff + 27'h000_0001;
	end

	// Calendar kept to weekday and date; months are not modelled
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			sec_ff <= RST_TIME;
			min_ff <= RST_TIME;
			hour_ff <= RST_TIME;
			wday_ff <= RST_TIME;
			date_ff <= RST_DATE;
		end else if (wr_en_ff && wr_addr_ff <= OFS_DATE) begin
			unique case (wr_addr_ff)
				OFS_SECONDS: sec_ff <= wr_data_ff;
				OFS_MINUTES: min_ff <= wr_data_ff;
				OFS_HOURS: hour_ff <= wr_data_ff;
				OFS_WEEKDAY: wday_ff <= wr_data_ff;
				default: date_ff <= wr_data_ff;
			endcase
		end else if (sec_tick) begin
			sec_ff <= bcd_next(sec_ff, 8'h59, 8'h00);
			if (min_roll)
				min_ff <= bcd_next(min_ff, 8'h59, 8'h00);
			if (hour_roll)
				hour_ff <= bcd_next(hour_ff, 8'h23, 8'h00);
			if (day_roll) begin
				wday_ff <= bcd_next(wday_ff, 8'h06, 8'h00);
				date_ff <= bcd_next(date_ff, 8'h31, 8'h01);
			end
		end
	end

	// ------------------------------------------------------------
	// Periodic update
	// ------------------------------------------------------------
	// Events never stop; the enable gates the pin and the clock output start
	wire upd_evt = update_source_select ? min_roll : sec_tick;
	wire upd_clr = wr_stat && !wr_data_ff[B_UF];
	wire upd_expire = upd_cnt_ff == 26'h000_0001;

	always_ff @(posedge ref_clk) begin
		if (!reset_n)
			update_flag_ff <= 1'b0;
		else if (upd_evt)
			update_flag_ff <= 1'b1;
		else if (upd_clr)
			update_flag_ff <= 1'b0;
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			upd_act_ff <= 1'b0;
			upd_cnt_ff <= 26'h000_0000;
		end else if (upd_evt && update_irq_enable) begin
			upd_act_ff <= 1'b1;
			upd_cnt_ff <= update_source_select ? 26'(RMIN_CYC) : 26'(RSEC_CYC);
		end else if (upd_expire || !update_flag_ff || !update_irq_enable) begin
			upd_act_ff <= 1'b0;
			upd_cnt_ff <= 26'h000_0000;
		end else begin
			upd_cnt_ff <= upd_cnt_ff - 26'h000_0001;
		end
	end

	// ------------------------------------------------------------
	// Alarm
	// ------------------------------------------------------------
	// Compared one cycle after the rollover, on the updated time
	wire [7:0] day_now = weekday_or_date_select ? date_ff : wday_ff;
	wire m_ok = !alm_min_ff[B_PART] || alm_min_ff[6:0] == min_ff[6:0];
	wire h_ok = !alm_hour_ff[B_PART] || alm_hour_ff[5:0] == hour_ff[5:0];
	wire d_ok = !alm_day_ff[B_PART] || alm_day_ff[5:0] == day_now[5:0];
	wire any_part = alm_min_ff[B_PART] | alm_hour_ff[B_PART] |
		alm_day_ff[B_PART];
	wire alarm_signal = alm_chk_ff && any_part && m_ok && h_ok && d_ok;

	always_ff @(posedge ref_clk) begin
		if (!reset_n)
			alm_chk_ff <= 1'b0;
		else
			alm_chk_ff <= min_roll;
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n)
			alarm_flag_ff <= 1'b0;
		else if (alarm_signal)
			alarm_flag_ff <= 1'b1;
		else if (wr_stat && !wr_data_ff[B_AF])
			alarm_flag_ff <= 1'b0;
	end

	// ------------------------------------------------------------
	// External event and time stamp
	// ------------------------------------------------------------
	wire evi_act = evi_s == event_polarity;
	wire edge_hit = evi_act && (evi_q_ff != evi_s);
	wire lvl_hit = lvl_cnt_ff == 3'(EVT_FILT_CYC - 1) && evi_act;
	wire ev_det = ettype == 2'h0 ? edge_hit : lvl_hit;
	wire event_signal = ev_det && !timestamp_source_select;
	wire bsw_hit = bsw_s && !bsw_q_ff && timestamp_source_select && timestamp_enable;
	wire ts_cap = (event_signal || bsw_hit) && timestamp_enable && !event_flag_ff;

	// Filter fires once per active level, then waits for release
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			evi_q_ff <= 1'b0;
			bsw_q_ff <= 1'b0;
			lvl_cnt_ff <= 3'h0;
		end else begin
			evi_q_ff <= evi_s;
			bsw_q_ff <= bsw_s;
			if (!evi_act)
				lvl_cnt_ff <= 3'h0;
			else if (lvl_cnt_ff != 3'(EVT_FILT_CYC))
				lvl_cnt_ff <= lvl_cnt_ff + 3'h1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n)
			event_flag_ff <= 1'b0;
		else if (event_signal || bsw_hit)
			event_flag_ff <= 1'b1;
		else if (wr_stat && !wr_data_ff[B_EVF])
			event_flag_ff <= 1'b0;
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			ts_sec_ff <= RST_TIME;
			ts_min_ff <= RST_TIME;
			ts_hour_ff <= RST_TIME;
			ts_date_ff <= RST_TIME;
		end else if (ts_cap) begin
			ts_sec_ff <= sec_ff;
			ts_min_ff <= min_ff;
			ts_hour_ff <= hour_ff;
			ts_date_ff <= date_ff;
		end
	end

	// ------------------------------------------------------------
	// Interrupt pin and clock output
	// ------------------------------------------------------------
	wire irq_any = upd_act_ff | (alarm_flag_ff & alarm_irq_enable) |
		(event_flag_ff & event_irq_enable);
	wire fd_ok = fdsel < FD_TIMER;
	wire auto_set = clock_irq_gate_enable && !clock_output_enable && fd_ok && (
		(upd_evt && update_irq_enable && mask_ff[B_UPDATE_CLOCK_GATE_ENABLE]) ||
		(alarm_signal && alarm_irq_enable && mask_ff[B_ALARM_CLOCK_GATE_ENABLE]) ||
		(event_signal && event_irq_enable && mask_ff[B_EVENT_CLOCK_GATE_ENABLE]));
	wire auto_hold = (update_flag_ff & mask_ff[B_UPDATE_CLOCK_GATE_ENABLE]) |
		(alarm_flag_ff & mask_ff[B_ALARM_CLOCK_GATE_ENABLE]) | (event_flag_ff & mask_ff[B_EVENT_CLOCK_GATE_ENABLE]);
	wire clk_run = (clock_output_enable && fd_ok) || clk_auto_ff;

	always_ff @(posedge ref_clk) begin
		if (!reset_n)
			int_n <= 1'b1;
		else
			int_n <= ~irq_any;
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n)
			clk_auto_ff <= 1'b0;
		else if (auto_set)
			clk_auto_ff <= 1'b1;
		else if (!auto_hold || !clock_irq_gate_enable)
			clk_auto_ff <= 1'b0;
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n || !clk_run) begin
			div_ff <= 26'h000_0000;
			clkout <= 1'b0;
		end else if (div_ff >= half_period(fdsel) - 26'h000_0001) begin
			div_ff <= 26'h000_0000;
			clkout <= ~clkout;
		end else begin
			div_ff <= div_ff + 26'h000_0001;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	sequence s_ts_armed;
		event_signal && timestamp_enable && !event_flag_ff;
	endsequence
	sequence s_ts_taken;
		event_flag_ff && ts_min_ff == $past(min_ff) &&
			ts_sec_ff == $past(sec_ff);
	endsequence

	property p_upd_source;
		upd_evt |-> (update_source_select ? (sec_tick && $past(sec_ff) != 8'h59 ? 1'b0 : 1'b1)
			&& sec_tick : sec_tick);
	endproperty
	a_upd_source: assert property (p_upd_source)
		else $error("update event off its rollover");

	property p_upd_flag_set;
		upd_evt |=> update_flag_ff ##1 update_flag_ff || $past(upd_clr);
	endproperty
	a_upd_flag_set: assert property (p_upd_flag_set)
		else $error("update flag not set");

	property p_upd_release_time;
		upd_act_ff && upd_expire && !(upd_evt && update_irq_enable) |=> !upd_act_ff;
	endproperty
	a_upd_release_time: assert property (p_upd_release_time)
		else $error("update pulse did not self-release");

	property p_upd_release_clear;
		upd_act_ff && upd_clr && !upd_evt ##1 !upd_evt |=> !upd_act_ff ##1
			(int_n || $past(irq_any));
	endproperty
	a_upd_release_clear: assert property (p_upd_release_clear)
		else $error("update pulse held after flag clear");

	property p_upd_flag_hold;
		update_flag_ff && !upd_clr |=> update_flag_ff;
	endproperty
	a_upd_flag_hold: assert property (p_upd_flag_hold)
		else $error("update flag dropped by hardware");

	property p_restart;
		wr_sec || wr_rst |=> presc_ff == 27'h000_0000 ##1
			(presc_ff == 27'h000_0001 || $past(wr_sec || wr_rst));
	endproperty
	a_restart: assert property (p_restart)
		else $error("period not restarted");

	property p_alarm_set;
		alarm_signal |=> alarm_flag_ff ##1 (!int_n || !alarm_irq_enable);
	endproperty
	a_alarm_set: assert property (p_alarm_set)
		else $error("alarm match not flagged");

	property p_alarm_minute;
		alarm_signal |-> $past(min_roll);
	endproperty
	a_alarm_minute: assert property (p_alarm_minute)
		else $error("alarm checked off the minute");

	property p_ts_capture;
		s_ts_armed |=> s_ts_taken;
	endproperty
	a_ts_capture: assert property (p_ts_capture)
		else $error("time stamp not captured");

	property p_bsw_flag;
		bsw_hit |=> event_flag_ff;
	endproperty
	a_bsw_flag: assert property (p_bsw_flag)
		else $error("switchover did not set event flag");

	property p_int_shared;
		irq_any |=> !int_n;
	endproperty
	a_int_shared: assert property (p_int_shared)
		else $error("request not on interrupt pin");

	property p_clk_auto;
		auto_set |=> clk_auto_ff ##2 clk_run;
	endproperty
	a_clk_auto: assert property (p_clk_auto)
		else $error("clock output not switched on");
endmodule : rei_event_core
`default_nettype wire

// [rei_event_core_bench.sv]
`default_nettype none
module rei_event_core_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import rei_pkg::*;
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic evt_pin = 1'b0;
	logic bkp = 1'b0;
	wire scl, sda, sda_out, sda_oe, int_n, clkout;
	int error_cnt = 0;
	int num_checks = 0;
	int cyc = 0;
	int n;
	logic [7:0] rv;
	always #5 ref_clk = !ref_clk;
	rei_event_core #(.SEC_CYC(2000), .RSEC_CYC(1000), .RMIN_CYC(20))
		rei_event_core_i (.ref_clk(ref_clk), .reset_n(reset_n),
		.scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
		.event_input_pin(evt_pin), .backup_switch_in(bkp),
		.int_n(int_n), .clkout(clkout));
	rei_host rei_host_i (.ref_clk(ref_clk), .sda_oe(sda_oe), .scl(scl),
		.sda(sda));
	task automatic chk(string nm, logic [15:0] s, logic [15:0] e);
		num_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("[FAIL] %s exp %h got %h", nm, e, s);
		end
	endtask : chk
	// Counts settled cycles until int_n reaches lvl, at most lim
	task automatic wait_int(logic lvl, int lim);
		#1;
		n = 0;
		while (int_n !== lvl && n < lim) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
	endtask : wait_int
	task automatic t_update;
		rei_host_i.wr(OFS_CTRL2, 8'h20);
		wait_int(1'b0, 2500);
		wait_int(1'b1, 1100);
		chk("pulse", n[15:0], 16'd1000);
		wait_int(1'b0, 2500);
		chk("period", n[15:0], 16'd1000);
		// Clearing the flag must end the pulse well before it times out
		rei_host_i.wr(OFS_STATUS, 8'h00);
		#1;
		chk("released", int_n, 1'b1);
		rei_host_i.rd(OFS_STATUS, rv);
		chk("uflag", rv[B_UF], 1'b0);
		rei_host_i.wr(OFS_CTRL2, 8'h00);
		wait_int(1'b0, 2500);
		chk("masked", n[15:0], 16'd2500);
		rei_host_i.rd(OFS_STATUS, rv);
		chk("uflag2", rv[B_UF], 1'b1);
		$display("update test done");
	endtask : t_update
	task automatic t_event;
		rei_host_i.wr(OFS_STATUS, 8'h00);
		rei_host_i.wr(OFS_EVT_CTRL, 8'h40);
		rei_host_i.wr(OFS_CLK_MASK, 8'h08);
		rei_host_i.wr(OFS_CLK_CFG, 8'h40);
		rei_host_i.wr(OFS_CTRL2, 8'h84);
		@(posedge ref_clk);
		evt_pin <= 1'b1;
		wait_int(1'b0, 20);
		chk("evt_int", int_n, 1'b0);
		// Auto-started clock output starts low and is high during its second half period
		repeat (1600) @(posedge ref_clk);
		#1;
		chk("clk_auto", clkout, 1'b1);
		rei_host_i.rd(OFS_STATUS, rv);
		chk("eflag", rv[B_EVF], 1'b1);
		rei_host_i.rd(OFS_TS_DATE, rv);
		chk("ts_date", rv, RST_DATE);
		rei_host_i.wr(OFS_CTRL2, 8'h80);
		wait_int(1'b1, 20);
		chk("evt_off", int_n, 1'b1);
		// Switchover as source: the cleared flag is set again
		rei_host_i.wr(OFS_STATUS, 8'h00);
		rei_host_i.wr(OFS_EVT_CTRL, 8'h01);
		bkp <= 1'b1;
		rei_host_i.rd(OFS_STATUS, rv);
		chk("bsw_flag", rv[B_EVF], 1'b1);
		$display("event test done");
	endtask : t_event
	task automatic t_alarm;
		rei_host_i.wr(OFS_CTRL2, 8'h00);
		rei_host_i.wr(OFS_ALM_MIN, 8'h5a);
		rei_host_i.rd(OFS_ALM_MIN, rv);
		chk("ram_byte", rv, 8'h5a);
		// Minute 01 and date 01 take part, the hour does not
		rei_host_i.wr(OFS_ALM_MIN, 8'h81);
		rei_host_i.wr(OFS_ALM_DAY, 8'h81);
		rei_host_i.wr(OFS_CTRL1, 8'h20);
		rei_host_i.wr(OFS_STATUS, 8'h00);
		rei_host_i.wr(OFS_CTRL2, 8'h08);
		// Seconds write restarts the prescaler: rollover one second on
		rei_host_i.wr(OFS_SECONDS, 8'h59);
		wait_int(1'b0, 2100);
		chk("alm_due", n > 1950 && n < 2000, 1'b1);
		rei_host_i.rd(OFS_STATUS, rv);
		chk("aflag", rv[B_AF], 1'b1);
		rei_host_i.wr(OFS_CTRL2, 8'h00);
		wait_int(1'b1, 20);
		chk("alm_off", int_n, 1'b1);
		$display("alarm test done");
	endtask : t_alarm
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : tally_and_finish
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			error_cnt++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (8) @(posedge ref_clk);
		reset_n <= 1'b1;
		repeat (10) @(posedge ref_clk);
		t_update();
		t_event();
		t_alarm();
		tally_and_finish();
	end
endmodule : rei_event_core_bench
`default_nettype wire

// [rei_host.sv]
`default_nettype none
module rei_host (
	input wire logic ref_clk, // System clock
	input wire logic sda_oe, // Device pulls data low
	output logic scl, // Serial clock
	output wire logic sda // Resolved data line
);
	timeunit 1ns;
	timeprecision 1ps;
	logic pull_ff = 1'b0;
	// Pull-up on the wire: high unless someone pulls it low
	assign sda = !(pull_ff || sda_oe);
	initial scl = 1'b1;
	task automatic ph(input logic c, input logic d);
		repeat (10) @(posedge ref_clk);
		scl <= c;
		pull_ff <= !d;
	endtask : ph
	task automatic st;
		ph(1'b0, 1'b1);
		ph(1'b1, 1'b1);
		ph(1'b1, 1'b0);
	endtask : st
	task automatic sp;
		ph(1'b0, 1'b0);
		ph(1'b1, 1'b0);
		ph(1'b1, 1'b1);
	endtask : sp
	// Release data in the ninth bit: device ack, or host nack on reads
	task automatic xb(input logic [7:0] w, output logic [7:0] r);
		for (int i = 7; i >= 0; i--) begin
			ph(1'b0, w[i]);
			ph(1'b1, w[i]);
			r[i] = sda;
		end
		ph(1'b0, 1'b1);
		ph(1'b1, 1'b1);
	endtask : xb
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] r;
		st();
		xb(8'ha4, r);
		xb(a, r);
		xb(d, r);
		sp();
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		logic [7:0] r;
		st();
		xb(8'ha4, r);
		xb(a, r);
		st();
		xb(8'ha5, r);
		xb(8'hff, d);
		sp();
	endtask : rd
endmodule : rei_host
`default_nettype wire

// [rei_pin_sync.sv]
`default_nettype none
module rei_pin_sync #(
	parameter int W = 4,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic ref_clk, // System clock
	input wire logic reset_n, // Synchronous reset, active low
	input wire logic [W-1:0] pin_in, // Asynchronous pins
	output logic [W-1:0] pin_out // Filtered, synchronous pins
);
	logic [W-1:0] s1_ff, s2_ff, s3_ff;

	// A new level is taken only when stages two and three agree
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			s1_ff <= RST_VAL;
			s2_ff <= RST_VAL;
			s3_ff <= RST_VAL;
			pin_out <= RST_VAL;
		end else begin
			s1_ff <= pin_in;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			for (int i = 0; i < W; i++) begin
				if (s2_ff[i] == s3_ff[i])
					pin_out[i] <= s3_ff[i];
			end
		end
	end
endmodule : rei_pin_sync
`default_nettype wire

// [rei_pkg.sv]
`default_nettype none
package rei_pkg;
	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_SECONDS = 8'h00;
	localparam logic [7:0] OFS_MINUTES = 8'h01;
	localparam logic [7:0] OFS_HOURS = 8'h02;
	localparam logic [7:0] OFS_WEEKDAY = 8'h03;
	localparam logic [7:0] OFS_DATE = 8'h04;
	localparam logic [7:0] OFS_ALM_MIN = 8'h07;
	localparam logic [7:0] OFS_ALM_HOUR = 8'h08;
	localparam logic [7:0] OFS_ALM_DAY = 8'h09;
	localparam logic [7:0] OFS_STATUS = 8'h0e;
	localparam logic [7:0] OFS_CTRL1 = 8'h0f;
	localparam logic [7:0] OFS_CTRL2 = 8'h10;
	localparam logic [7:0] OFS_CLK_MASK = 8'h12;
	localparam logic [7:0] OFS_EVT_CTRL = 8'h13;
	localparam logic [7:0] OFS_TS_SEC = 8'h15;
	localparam logic [7:0] OFS_TS_MIN = 8'h16;
	localparam logic [7:0] OFS_TS_HOUR = 8'h17;
	localparam logic [7:0] OFS_TS_DATE = 8'h18;
	localparam logic [7:0] OFS_CLK_CFG = 8'h35;
	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int B_UF = 4;
	localparam int B_AF = 2;
	localparam int B_EVF = 1;
	localparam int B_UPDATE_SOURCE_SELECT = 4;
	localparam int B_WEEKDAY_OR_DATE_SELECT = 5;
	localparam int B_TSE = 7;
	localparam int B_UIE = 5;
	localparam int B_AIE = 3;
	localparam int B_EIE = 2;
	localparam int B_RESET = 0;
	localparam int B_EVENT_CLOCK_GATE_ENABLE = 3;
	localparam int B_ALARM_CLOCK_GATE_ENABLE = 2;
	localparam int B_UPDATE_CLOCK_GATE_ENABLE = 0;
	localparam int B_EHL = 6;
	localparam int B_ET_HI = 5;
	localparam int B_ET_LO = 4;
	localparam int B_TSS = 0;
	localparam int B_CLOCK_OUTPUT_ENABLE = 7;
	localparam int B_CLOCK_IRQ_GATE_ENABLE = 6;
	localparam int B_PART = 7;
	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] RST_TIME = 8'h00;
	localparam logic [7:0] RST_DATE = 8'h01;
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [7:0] RST_CLK_CFG = 8'h07;
	localparam logic [2:0] FD_TIMER = 3'h6;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ = 100;
	localparam int ONE_SEC_US = 1000000;
	localparam int REL_SEC_US = 500000;
	localparam int REL_MIN_US = 7813;
	localparam int ONE_SEC_CYC = ONE_SEC_US * CLK_MHZ;
	localparam int REL_SEC_CYC = REL_SEC_US * CLK_MHZ;
	localparam int REL_MIN_CYC = REL_MIN_US * CLK_MHZ;
	localparam int EVT_FILT_CYC = 4;
	// Half periods of the clock output, per frequency select code
	localparam int HALF_32K = 1526;
	localparam int HALF_8K = 6104;
	localparam int HALF_1K = 48828;
	localparam int HALF_64 = 781250;
	localparam int HALF_32 = 1562500;
	localparam int HALF_1 = 50000000;
	// ------------------------------------------------------------
	// Serial port states, Gray coded along the write path
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_DEV = 4'h1,
		ST_DACK = 4'h3,
		ST_PTR = 4'h2,
		ST_PACK = 4'h6,
		ST_WDAT = 4'h7,
		ST_WACK = 4'h5,
		ST_RDAT = 4'h4,
		ST_RACK = 4'hc
	} rei_i2c_st_t;
endpackage : rei_pkg
`default_nettype wire
